// File: verilog/pst_consts.vh
// Constants shared by the panel scan and tear-sync logic
`ifndef PST_CONSTS_VH
`define PST_CONSTS_VH

// Command codes seen on the command port
`define PST_CMD_TEAR_OFF      8'h34
`define PST_CMD_TEAR_ON       8'h35
// Parameter bit of the enable command that picks mode two
`define PST_PARAM_MODE_BIT    0

// Panel geometry
`define PST_LINES             320
`define PST_LAST_LINE         9'h13F
`define PST_HALF_LINES        9'h0A0

// Clock and timing figures
`define PST_CLK_PERIOD_NS     20
`define PST_TVDH_MIN_US       1000
`define PST_THDH_MAX_US       500
// Least vertical high time, rounded up to whole cycles
`define PST_VBLANK_CYC  ((`PST_TVDH_MIN_US*1000+`PST_CLK_PERIOD_NS-1)/`PST_CLK_PERIOD_NS)
// Longest horizontal high time, rounded down to whole cycles
`define PST_HBLANK_MAX_CYC    ((`PST_THDH_MAX_US*1000)/`PST_CLK_PERIOD_NS)
// Chosen line phases in cycles
`define PST_HBLANK_CYC        16'h01F4
`define PST_ACTIVE_CYC        16'h079B
`define PST_FRONT_CYC         16'h0064

// Reset values
`define PST_RST_TEAR_EN       1'b0
`define PST_RST_TEAR_MODE     1'b0

`endif

// File: verilog/pst_gate_seq.v
// Gate line order generator: maps scan step to physical gate line
`timescale 1ns/1ps
`include "pst_consts.vh"

module pst_gate_seq
(
  input  wire       ref_clk_i,      // System clock
  input  wire       rst_i,          // Synchronous reset, active high
  input  wire       frame_start_i,  // Pulse: restart order, latch mode bits
  input  wire       step_i,         // Pulse: advance to next line
  input  wire       reverse_i,      // Scan reverse control
  input  wire       interlace_i,    // Interlace control
  output reg  [8:0] line_idx_o      // Gate index 0..319 (G1..G320)
);

  reg       rev;          // Reverse bit held for the frame
  reg       ilace;        // Interlace bit held for the frame
  reg [8:0] step;         // Scan step within the frame
  reg [8:0] next_idx;     // Index for the next step
  reg [8:0] next_step;    // Step after advance
  reg [8:0] half_ofs;     // Step within the second half
  reg       next_rev;
  reg       next_ilace;

  ////////////////////////////////////////////////////////////////////
  // Step bookkeeping; mode bits change only at frame start so a
  // field never mixes two orders
  always @*
  begin
    next_rev   = rev;
    next_ilace = ilace;
    next_step  = step;
    if (frame_start_i)
    begin
      next_rev   = reverse_i;
      next_ilace = interlace_i;
      next_step  = 9'h000;
    end
    else if (step_i && step != `PST_LAST_LINE)
      next_step = step + 9'h001;
    half_ofs = next_step - `PST_HALF_LINES;
    // Map step to index
    if (!next_ilace)
      next_idx = next_rev ? (`PST_LAST_LINE - next_step) : next_step;
    else if (!next_rev)
      next_idx = (next_step < `PST_HALF_LINES) ? {next_step[7:0], 1'b0}
                                                : {half_ofs[7:0], 1'b1};
    else
      next_idx = (next_step < `PST_HALF_LINES)
                 ? (`PST_LAST_LINE - {next_step[7:0], 1'b0})
                 : (`PST_LAST_LINE - {half_ofs[7:0], 1'b1});
  end

  ////////////////////////////////////////////////////////////////////
  // Registers
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rev        <= 1'b0;
      ilace      <= 1'b0;
      step       <= 9'h000;
      line_idx_o <= 9'h000;
    end
    else
    begin
      rev        <= next_rev;
      ilace      <= next_ilace;
      step       <= next_step;
      line_idx_o <= next_idx;
    end
  end

endmodule

// File: verilog/pst_top.v
// Panel scan timing with gate line drive and tear-sync output
`timescale 1ns/1ps
`include "pst_consts.vh"

module pst_top
#(
  // Vertical blank length in cycles; shorten for simulation only
  parameter [15:0] VBLANK_CYC = `PST_VBLANK_CYC
)
(
  input  wire         ref_clk_i,               // 50 MHz system clock
  input  wire         rst_i,                   // Synchronous reset, high
  input  wire         cmd_strobe_i,            // Pulse: command valid
  input  wire [7:0]   cmd_code_i,              // Command code
  input  wire [7:0]   cmd_param_i,             // Parameter with the code
  input  wire         gate_scan_reverse_i,     // Scan direction reverse
  input  wire         gate_interlace_select_i, // Interlaced scan select
  output reg          tear_sync_out_o,         // Tear-sync to host
  output reg          tear_enable_o,           // Tear output enabled
  output reg          tear_mode_o,             // 0: V only, 1: V and H
  output reg          vblank_o,                // Panel in vertical blank
  output reg  [8:0]   scan_line_o,             // Gate index being driven
  output reg  [319:0] gate_on_level_o,         // High: gate at on level
  output reg  [319:0] gate_off_level_o         // High: gate at off level
);

  ////////////////////////////////////////////////////////////////////
  // Timing constants

  // Horizontal blank phase; kept well under the longest allowed
  localparam [15:0] HBLANK_CYC = `PST_HBLANK_CYC;
  // Ceiling on the horizontal phase, checked by the chosen figure
  localparam [15:0] HBLANK_MAX = `PST_HBLANK_MAX_CYC;
  // Active refresh phase of one line
  localparam [15:0] ACTIVE_CYC = `PST_ACTIVE_CYC;
  // Short low gap between the last line and vertical blank
  localparam [15:0] FRONT_CYC  = `PST_FRONT_CYC;
  // Hblank actually used, never above the ceiling
  localparam [15:0] HBL_USE    = (HBLANK_CYC > HBLANK_MAX) ? HBLANK_MAX
                                                           : HBLANK_CYC;

  ////////////////////////////////////////////////////////////////////
  // Scan states
  localparam [1:0] ST_VBLANK = 2'b00;  // Panel not refreshed
  localparam [1:0] ST_ACTIVE = 2'b01;  // One line refreshed from memory
  localparam [1:0] ST_HBLANK = 2'b10;  // Between two lines
  localparam [1:0] ST_FRONT  = 2'b11;  // Gap before vertical blank

  ////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [1:0]  state;          // Current scan state
  reg  [1:0]  next_state;     // Next scan state
  reg  [15:0] cyc;            // Cycles spent in the state
  reg  [15:0] next_cyc;       // Next cycle count
  reg  [8:0]  lines;          // Lines refreshed this frame
  reg  [8:0]  next_lines;     // Next line count
  reg         frame_start;    // Pulse into the order generator
  reg         step;           // Pulse: move to next gate line
  reg         next_en;        // Next tear enable
  reg         next_mode;      // Next tear mode
  reg         next_tear;      // Next tear output level
  reg         gate_live;      // A gate line is being driven next cycle
  wire [8:0]  line_idx;       // Gate index from the order generator

  ////////////////////////////////////////////////////////////////////
  // Gate order generator
  pst_gate_seq u_seq
  (
    .ref_clk_i     (ref_clk_i),
    .rst_i         (rst_i),
    .frame_start_i (frame_start),
    .step_i        (step),
    .reverse_i     (gate_scan_reverse_i),
    .interlace_i   (gate_interlace_select_i),
    .line_idx_o    (line_idx)
  );

  ////////////////////////////////////////////////////////////////////
  // Command decode: enable, disable and mode select
  always @*
  begin
    next_en   = tear_enable_o;
    next_mode = tear_mode_o;
    if (cmd_strobe_i)
    begin
      case (cmd_code_i)
        `PST_CMD_TEAR_OFF:
        begin
          // Mode is left as is; only the output goes quiet
          next_en = 1'b0;
        end
        `PST_CMD_TEAR_ON:
        begin
          next_en   = 1'b1;
          next_mode = cmd_param_i[`PST_PARAM_MODE_BIT];
        end
        default:
        begin
          // Other codes belong to other blocks
          next_en   = tear_enable_o;
          next_mode = tear_mode_o;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Scan sequencer: vblank, then 320 lines of active and hblank
  always @*
  begin
    next_state  = state;
    next_cyc    = cyc + 16'h0001;
    next_lines  = lines;
    frame_start = 1'b0;
    step        = 1'b0;
    case (state)
      ST_VBLANK:
      begin
        // Held for at least the least vertical high time
        if (cyc >= VBLANK_CYC - 16'h0001)
        begin
          next_state  = ST_ACTIVE;
          next_cyc    = 16'h0000;
          next_lines  = 9'h000;
          frame_start = 1'b1;
        end
      end
      ST_ACTIVE:
      begin
        if (cyc == ACTIVE_CYC - 16'h0001)
        begin
          next_state = ST_HBLANK;
          next_cyc   = 16'h0000;
        end
      end
      ST_HBLANK:
      begin
        // Every line ends in one hblank, so a field holds 320 of them
        if (cyc == HBL_USE - 16'h0001)
        begin
          next_cyc = 16'h0000;
          if (lines == `PST_LAST_LINE)
            next_state = ST_FRONT;
          else
          begin
            next_state = ST_ACTIVE;
            next_lines = lines + 9'h001;
            step       = 1'b1;
          end
        end
      end
      ST_FRONT:
      begin
        // Low gap keeps the last hblank apart from the vertical pulse
        if (cyc == FRONT_CYC - 16'h0001)
        begin
          next_state = ST_VBLANK;
          next_cyc   = 16'h0000;
        end
      end
      default:
      begin
        next_state = ST_VBLANK;
        next_cyc   = 16'h0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Tear output level for the next cycle
  always @*
  begin
    gate_live = (next_state == ST_ACTIVE);
    if (!next_en)
      next_tear = 1'b0;
    else if (next_state == ST_VBLANK)
      next_tear = 1'b1;
    else if (next_state == ST_HBLANK)
      next_tear = next_mode;
    else
      next_tear = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Control registers and sequencer state
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state           <= ST_VBLANK;
      cyc             <= 16'h0000;
      lines           <= 9'h000;
      tear_enable_o   <= `PST_RST_TEAR_EN;
      tear_mode_o     <= `PST_RST_TEAR_MODE;
      tear_sync_out_o <= 1'b0;
      vblank_o        <= 1'b1;
      scan_line_o     <= 9'h000;
    end
    else
    begin
      state           <= next_state;
      cyc             <= next_cyc;
      lines           <= next_lines;
      tear_enable_o   <= next_en;
      tear_mode_o     <= next_mode;
      tear_sync_out_o <= next_tear;
      vblank_o        <= (next_state == ST_VBLANK);
      scan_line_o     <= line_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Gate drive: exactly one line at the on level during active
  // refresh, all lines off otherwise. The order generator index is
  // already valid when the active phase begins, since it is updated
  // on the same edge that enters the state.
  genvar k;
  generate
    for (k = 0; k < `PST_LINES; k = k + 1)
    begin : g_gate
      localparam [8:0] IDX = k;
      always @(posedge ref_clk_i)
      begin
        if (rst_i)
        begin
          gate_on_level_o[k]  <= 1'b0;
          gate_off_level_o[k] <= 1'b1;
        end
        else
        begin
          gate_on_level_o[k]  <= (state == ST_ACTIVE) && (line_idx == IDX);
          gate_off_level_o[k] <= !((state == ST_ACTIVE) && (line_idx == IDX));
        end
      end
    end
  endgenerate

  // The host side uses tear_sync_out_o to pace its memory writes;
  // nothing here waits on it.

endmodule

// File: tb/pst_check_monitor.sv
// Checker for tear-sync and gate drive behaviour of the scan block
`timescale 1ns/1ps
module pst_check_monitor #(parameter [15:0] VBLANK_CYC = 16'hC350)
(
  input wire logic         ref_clk_i,
  input wire logic         rst_i,
  input wire logic         cmd_strobe_i,
  input wire logic [7:0]   cmd_code_i,
  input wire logic [7:0]   cmd_param_i,
  input wire logic         gate_scan_reverse_i,
  input wire logic         gate_interlace_select_i,
  input wire logic         tear_sync_out_o,
  input wire logic         tear_enable_o,
  input wire logic         tear_mode_o,
  input wire logic         vblank_o,
  input wire logic [8:0]   scan_line_o,
  input wire logic [319:0] gate_on_level_o,
  input wire logic [319:0] gate_off_level_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  wire         mode_req = cmd_param_i[0]; // Mode bit carried with the enable
  logic [15:0] v_run;                     // Cycles of vertical blank so far
  logic [15:0] h_run;                     // Cycles of tear high outside vblank
  // Run counters; cleared on each low phase so only whole runs count
  always @(posedge ref_clk_i)
  begin
    v_run <= (rst_i || !vblank_o) ? 16'h0000 : v_run + 16'h0001;
    h_run <= (rst_i || vblank_o || !tear_sync_out_o) ? 16'h0000 : h_run + 16'h0001;
  end
  sequence on_cmd;
    cmd_strobe_i && cmd_code_i == 8'h35;
  endsequence
  sequence off_cmd;
    cmd_strobe_i && cmd_code_i == 8'h34;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  tear_gated_a: assert property (!tear_enable_o |-> !tear_sync_out_o)
    else $error("tear output high while disabled");
  tear_on_a: assert property (on_cmd |=> tear_enable_o && tear_mode_o == $past(mode_req))
    else $error("enable command did not set state");
  tear_off_a: assert property (off_cmd |=> !tear_enable_o && $stable(tear_mode_o))
    else $error("disable command did not clear enable");
  state_hold_a: assert property (!(cmd_strobe_i && (cmd_code_i == 8'h34 || cmd_code_i == 8'h35))
    |=> $stable(tear_enable_o) && $stable(tear_mode_o))
    else $error("tear state changed without command");
  vblank_high_a: assert property (tear_enable_o && vblank_o |-> tear_sync_out_o)
    else $error("tear low in vertical blank");
  mode_one_a: assert property (tear_enable_o && !tear_mode_o |-> tear_sync_out_o == vblank_o)
    else $error("mode one output not vertical blank");
  vblank_len_a: assert property ($fell(vblank_o) |-> v_run >= VBLANK_CYC - 16'h0001)
    else $error("vertical blank too short");
  hblank_len_a: assert property (h_run <= 16'h61A8)
    else $error("horizontal blank high too long");
  gate_hot_a: assert property ($onehot0(gate_on_level_o) && gate_off_level_o == ~gate_on_level_o)
    else $error("gate levels not one line on");
endmodule
bind pst_top pst_check_monitor #(.VBLANK_CYC(VBLANK_CYC)) u_mon (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_strobe_i(cmd_strobe_i),
  .cmd_code_i(cmd_code_i), .cmd_param_i(cmd_param_i), .gate_scan_reverse_i(gate_scan_reverse_i),
  .gate_interlace_select_i(gate_interlace_select_i), .tear_sync_out_o(tear_sync_out_o),
  .tear_enable_o(tear_enable_o), .tear_mode_o(tear_mode_o), .vblank_o(vblank_o),
  .scan_line_o(scan_line_o), .gate_on_level_o(gate_on_level_o),
  .gate_off_level_o(gate_off_level_o));

// File: tb/pst_host_model.sv
// Host controller model issuing tear-sync commands on the command port
`timescale 1ns/1ps
module pst_host_model
(
  input  wire logic       ref_clk_i,
  output logic            cmd_strobe_o,
  output logic      [7:0] cmd_code_o,
  output logic      [7:0] cmd_param_o
);
  initial
  begin
    cmd_strobe_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_param_o = 8'h00;
  end
  // The host model only drives the command port; it never reads the tear output
  // One command per call; calls may follow each other with no gap
  task automatic issue(input [7:0] code, input [7:0] param);
    @(negedge ref_clk_i);
    cmd_strobe_o = 1'b1;
    cmd_code_o = code;
    cmd_param_o = param;
  endtask
  // Released lines flip so stale values never look valid
  task automatic idle();
    @(negedge ref_clk_i);
    cmd_strobe_o = 1'b0;
    cmd_code_o = ~cmd_code_o;
    cmd_param_o = ~cmd_param_o;
  endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the panel scan and tear-sync block
`timescale 1ns/1ps
module tb;
  logic         ref_clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         rev = 1'b0;   // Scan reverse level
  logic         ilc = 1'b0;   // Interlace level
  wire          stb;
  wire  [7:0]   code;
  wire  [7:0]   param;
  wire          tear, en, mode, vbl;
  wire  [8:0]   line;
  wire  [319:0] gon, goff;
  int           n_fail = 0;
  int           total_checks = 0;
  int           cyc = 0;      // Cycle count for the hang guard
  initial forever #10 ref_clk_i = ~ref_clk_i;
  pst_host_model host (.ref_clk_i(ref_clk_i), .cmd_strobe_o(stb), .cmd_code_o(code),
    .cmd_param_o(param));
  // Short vertical blank keeps each frame start cheap to reach
  pst_top #(.VBLANK_CYC(16'h0014)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .cmd_strobe_i(stb), .cmd_code_i(code), .cmd_param_i(param), .gate_scan_reverse_i(rev),
    .gate_interlace_select_i(ilc), .tear_sync_out_o(tear), .tear_enable_o(en),
    .tear_mode_o(mode), .vblank_o(vbl), .scan_line_o(line), .gate_on_level_o(gon),
    .gate_off_level_o(goff));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard well above the first three lines of each of the four frames run here
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      n_fail++;
      results();
    end
  end
  task automatic check(input string name, input [319:0] seen, input [319:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Bounded wait for a gate line to turn on or for all to turn off
  task automatic wait_gate(input logic on);
    int n;
    n = 0;
    while (((gon !== 320'h0) != on) && n < 3000)
    begin
      step(1);
      n++;
    end
  endtask
  // Gate index of scan step k; only the first half of an interlaced field
  function automatic [8:0] exp_idx(input logic il, input logic rv, input int k);
    int s;
    s = il ? 2 * k : k;
    exp_idx = rv ? 9'(319 - s) : 9'(s);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // Scan bits are only taken at frame start, so each order gets a reset
    for (int i = 0; i < 4; i++)
    begin
      rst_i = 1'b1;
      ilc = i[1];
      rev = i[0];
      step(12);
      rst_i = 1'b0;
      check("tear_out", tear, 1'b0);
      check("tear_enable", en, 1'b0);
      host.issue(8'h35, {7'h00, i[0]});
      host.idle();
      check("tear_enable", en, 1'b1);
      check("tear_mode", mode, i[0]);
      check("tear_vblank", tear, 1'b1);
      check("vblank", vbl, 1'b1);
      for (int k = 0; k < 3; k++)
      begin
        wait_gate(1'b1);
        check("gate_on", gon, 320'h1 << exp_idx(i[1], i[0], k));
        check("gate_off", goff, ~(320'h1 << exp_idx(i[1], i[0], k)));
        check("scan_line", line, exp_idx(i[1], i[0], k));
        check("vblank_act", vbl, 1'b0);
        step(1000);
        check("tear_active", tear, 1'b0);
        wait_gate(1'b0);
        step(5);
        check("tear_hblank", tear, i[0]);
      end
    end
    host.issue(8'h36, 8'h00);
    host.idle();
    check("tear_enable", en, 1'b1);
    host.issue(8'h34, 8'hFF);
    host.idle();
    check("tear_enable", en, 1'b0);
    check("tear_out", tear, 1'b0);
    check("tear_mode", mode, 1'b1);
    host.issue(8'h34, 8'h00);
    host.issue(8'h35, 8'h00);
    host.idle();
    check("tear_enable", en, 1'b1);
    check("tear_mode", mode, 1'b0);
    results();
  end
endmodule
